// ===== spg_defs.svh
`ifndef SPG_DEFS_SVH
`define SPG_DEFS_SVH

// core control register field positions
`define SPG_CCR_BROWNOUT_SLEEP_OFF 7
`define SPG_CCR_ARM 5
`define SPG_CCR_SM_HI 4
`define SPG_CCR_SM_LO 3
`define SPG_CCR_UNLOCK 2
`define SPG_CCR_RESET 8'h00

// power gate register field positions
`define SPG_PGR_TIMER1 3
`define SPG_PGR_TIMER0 2
`define SPG_PGR_SERIAL 1
`define SPG_PGR_ADC 0
`define SPG_PGR_RESET 4'h0

// sleep mode select encodings
`define SPG_SM_IDLE 2'h0
`define SPG_SM_NOISE 2'h1
`define SPG_SM_PDOWN 2'h2

// timed brown-out sleep sequence, in clock cycles
`define SPG_UNLOCK_WIN 3'h4
`define SPG_BROWNOUT_SLEEP_OFF_LEN 3'h6
`define SPG_BROWNOUT_SLEEP_OFF_HOLD 3'h3

// wake timing defaults, in clock cycles
`define SPG_WAKE_HALT 4
`define SPG_WAKE_CYC 16
`define SPG_RESET_WAKE_CYC 1024
`define SPG_VREF_START_CYC 40

`endif

// ===== spg_pkg.sv
package spg_pkg;

	typedef enum logic [2:0] {
		SPG_ACTIVE = 3'h0,
		SPG_IDLE = 3'h1,
		SPG_NOISE = 3'h2,
		SPG_PDOWN = 3'h3,
		SPG_WAKE = 3'h4
	} spg_mode_t;

	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic pck;
	} spg_clk_t;

	typedef struct packed {
		logic any_irq;
		logic adc_done_irq;
		logic spm_ready_irq;
		logic serial_start_irq;
		logic ext0_level_irq;
		logic pin_change_irq;
		logic wdt_reset_evt;
		logic bod_reset_evt;
	} spg_wake_t;

	typedef struct packed {
		spg_mode_t st;
		logic arm;
		logic [1:0] msel;
		logic [2:0] unlock_cnt;
		logic [2:0] brownout_sleep_off_cnt;
		logic [3:0] pgr;
		logic bod_off;
		logic [15:0] wake_cnt;
		logic [15:0] vref_cnt;
		logic adc_d;
		logic adc_ext;
	} spg_state_t;

endpackage

// ===== spg_ctrl.sv
`timescale 1ns/10ps
`include "spg_defs.svh"

module spg_ctrl
	import spg_pkg::*;
#(
	parameter int WAKE_CYC = `SPG_WAKE_CYC,
	parameter int RESET_WAKE_CYC = `SPG_RESET_WAKE_CYC,
	parameter int VREF_START_CYC = `SPG_VREF_START_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// core control register write and read
	input wire logic ccr_wr,
	input wire logic [7:0] ccr_wdata,
	output logic [7:0] ccr_rdata,
	// power gate register write and read
	input wire logic pgr_wr,
	input wire logic [7:0] pgr_wdata,
	output logic [7:0] pgr_rdata,
	// core sleep instruction and state
	input wire logic sleep_exec,
	output logic cpu_run,
	output logic sleeping,
	// wake sources
	input wire spg_wake_t wake_in,
	// fuses and peripheral enables
	input wire logic bod_fuse_en,
	input wire logic wdt_enable,
	input wire logic adc_enable,
	input wire logic acomp_enable,
	input wire logic adc_conv_start,
	// peripheral register access, one bit per gated peripheral
	input wire logic [3:0] periph_io_req,
	output logic [3:0] periph_io_ack,
	// port pin input buffers
	input wire logic [5:0] din_disable,
	input wire logic [5:0] wake_pin_mask,
	output logic [5:0] input_buf_en,
	// clock and analog controls
	output spg_clk_t clk_en,
	output logic [3:0] periph_clk_en,
	output logic osc_enable,
	output logic async_keep_en,
	output logic wdt_run,
	output logic bod_enable,
	output logic acomp_active,
	output logic adc_active,
	output logic adc_extended,
	output logic vref_enable,
	output logic vref_ready
);

	spg_state_t r_reg;
	spg_state_t r_next;
	logic brownout_sleep_off_bit;
	logic brownout_sleep_off_act;
	logic wake_hit;

	assign brownout_sleep_off_bit = (r_reg.brownout_sleep_off_cnt != 3'h0);
	assign brownout_sleep_off_act = brownout_sleep_off_bit && (r_reg.brownout_sleep_off_cnt <= `SPG_BROWNOUT_SLEEP_OFF_HOLD);

	// wake source filter per sleep mode
	always_comb begin
		case (r_reg.st)
			SPG_IDLE: begin
				wake_hit = wake_in.any_irq | wake_in.wdt_reset_evt | wake_in.bod_reset_evt;
			end
			SPG_NOISE: begin
				wake_hit = wake_in.adc_done_irq | wake_in.spm_ready_irq | wake_in.ext0_level_irq
					| wake_in.pin_change_irq | wake_in.wdt_reset_evt | wake_in.bod_reset_evt;
			end
			SPG_PDOWN: begin
				wake_hit = wake_in.serial_start_irq | wake_in.ext0_level_irq
					| wake_in.pin_change_irq | wake_in.wdt_reset_evt | wake_in.bod_reset_evt;
			end
			default: begin
				wake_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		r_next = r_reg;
		// timed unlock window and sleep-off bit count down on their own
		if (r_reg.unlock_cnt != 3'h0) begin
			r_next.unlock_cnt = r_reg.unlock_cnt - 3'h1;
		end
		if (brownout_sleep_off_bit) begin
			r_next.brownout_sleep_off_cnt = r_reg.brownout_sleep_off_cnt - 3'h1;
		end
		if (ccr_wr) begin
			r_next.arm = ccr_wdata[`SPG_CCR_ARM];
			r_next.msel = ccr_wdata[`SPG_CCR_SM_HI:`SPG_CCR_SM_LO];
			if (ccr_wdata[`SPG_CCR_BROWNOUT_SLEEP_OFF] && ccr_wdata[`SPG_CCR_UNLOCK]) begin
				r_next.unlock_cnt = `SPG_UNLOCK_WIN;
			end else if (ccr_wdata[`SPG_CCR_BROWNOUT_SLEEP_OFF] && (r_reg.unlock_cnt != 3'h0)) begin
				// a plain write of one outside the window is ignored
				r_next.brownout_sleep_off_cnt = `SPG_BROWNOUT_SLEEP_OFF_LEN;
				r_next.unlock_cnt = 3'h0;
			end
		end
		if (pgr_wr) begin
			r_next.pgr = pgr_wdata[3:0];
		end
		// converter re-enable marks the next conversion as extended
		r_next.adc_d = adc_enable;
		if (adc_enable && !r_reg.adc_d) begin
			r_next.adc_ext = 1'b1;
		end else if (adc_conv_start) begin
			r_next.adc_ext = 1'b0;
		end
		// reference start-up counter restarts whenever the reference drops
		if (!vref_enable) begin
			r_next.vref_cnt = 16'(VREF_START_CYC);
		end else if (r_reg.vref_cnt != 16'h0) begin
			r_next.vref_cnt = r_reg.vref_cnt - 16'h1;
		end
		case (r_reg.st)
			SPG_ACTIVE: begin
				if (sleep_exec && r_reg.arm) begin
					case (r_reg.msel)
						`SPG_SM_IDLE: r_next.st = SPG_IDLE;
						`SPG_SM_NOISE: r_next.st = SPG_NOISE;
						`SPG_SM_PDOWN: begin
							r_next.st = SPG_PDOWN;
							r_next.bod_off = brownout_sleep_off_act;
						end
						default: r_next.st = SPG_ACTIVE;
					endcase
				end
			end
			SPG_IDLE, SPG_NOISE, SPG_PDOWN: begin
				if (wake_hit) begin
					r_next.st = SPG_WAKE;
					r_next.bod_off = 1'b0;
					if (r_reg.st != SPG_PDOWN) begin
						r_next.wake_cnt = 16'(`SPG_WAKE_HALT);
					end else if (r_reg.bod_off) begin
						r_next.wake_cnt = 16'(RESET_WAKE_CYC + `SPG_WAKE_HALT);
					end else begin
						r_next.wake_cnt = 16'(WAKE_CYC + `SPG_WAKE_HALT);
					end
				end
			end
			SPG_WAKE: begin
				if (r_reg.wake_cnt <= 16'h1) begin
					r_next.st = SPG_ACTIVE;
					r_next.wake_cnt = 16'h0;
				end else begin
					r_next.wake_cnt = r_reg.wake_cnt - 16'h1;
				end
			end
			default: begin
				r_next.st = SPG_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{st: SPG_ACTIVE, arm: 1'b0, msel: 2'h0, unlock_cnt: 3'h0,
				brownout_sleep_off_cnt: 3'h0, pgr: `SPG_PGR_RESET, bod_off: 1'b0, wake_cnt: 16'h0,
				vref_cnt: 16'h0, adc_d: 1'b0, adc_ext: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// register read views; unused and reserved bits read zero
	always_comb begin
		ccr_rdata = `SPG_CCR_RESET;
		ccr_rdata[`SPG_CCR_BROWNOUT_SLEEP_OFF] = brownout_sleep_off_bit;
		ccr_rdata[`SPG_CCR_ARM] = r_reg.arm;
		ccr_rdata[`SPG_CCR_SM_HI:`SPG_CCR_SM_LO] = r_reg.msel;
		ccr_rdata[`SPG_CCR_UNLOCK] = (r_reg.unlock_cnt != 3'h0);
	end
	assign pgr_rdata = {4'h0, r_reg.pgr};

	// clock domains per state; the wake period runs the oscillator but holds the core
	always_comb begin
		clk_en.cpu = (r_reg.st == SPG_ACTIVE);
		clk_en.flash = (r_reg.st == SPG_ACTIVE);
		clk_en.io = (r_reg.st == SPG_ACTIVE) || (r_reg.st == SPG_IDLE) || (r_reg.st == SPG_WAKE);
		clk_en.pck = clk_en.io;
		clk_en.adc = clk_en.io || (r_reg.st == SPG_NOISE);
	end
	assign osc_enable = (r_reg.st != SPG_PDOWN);
	assign async_keep_en = 1'b1;
	assign wdt_run = wdt_enable;
	assign cpu_run = clk_en.cpu;
	assign sleeping = (r_reg.st != SPG_ACTIVE) && (r_reg.st != SPG_WAKE);

	// gating only bites where the domain runs; a stopped clock freezes state, so
	// restoring it resumes exactly where it stopped
	assign periph_clk_en[`SPG_PGR_TIMER1] = clk_en.io && !r_reg.pgr[`SPG_PGR_TIMER1];
	assign periph_clk_en[`SPG_PGR_TIMER0] = clk_en.io && !r_reg.pgr[`SPG_PGR_TIMER0];
	assign periph_clk_en[`SPG_PGR_SERIAL] = clk_en.io && !r_reg.pgr[`SPG_PGR_SERIAL];
	assign periph_clk_en[`SPG_PGR_ADC] = clk_en.adc && !r_reg.pgr[`SPG_PGR_ADC];
	assign periph_io_ack = periph_io_req & periph_clk_en;

	// analog controls
	assign bod_enable = bod_fuse_en && !r_reg.bod_off;
	assign acomp_active = acomp_enable && (r_reg.st != SPG_PDOWN);
	assign adc_active = adc_enable;
	assign adc_extended = r_reg.adc_ext;
	assign vref_enable = bod_enable || acomp_active || adc_active;
	assign vref_ready = vref_enable && (r_reg.vref_cnt == 16'h0);

	// input buffers: only wake pins survive when both clocks stop
	assign input_buf_en = ~din_disable
		& ((clk_en.io || clk_en.adc) ? 6'h3F : wake_pin_mask);

	property p_pd_entry;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_ACTIVE && sleep_exec && r_reg.arm && r_reg.msel == 2'h2)
			|=> (r_reg.st == SPG_PDOWN) && !osc_enable;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

	property p_unarmed;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_ACTIVE && sleep_exec && !r_reg.arm) |=> cpu_run;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("unarmed sleep took effect");

	property p_pd_clocks;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_PDOWN) |-> (clk_en == '0) && (periph_clk_en == 4'h0) && async_keep_en;
	endproperty
	a_pd_clocks: assert property (p_pd_clocks) else $error("clock running in power-down");

	property p_pd_wake;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_PDOWN && !wake_in.serial_start_irq && !wake_in.ext0_level_irq
			&& !wake_in.pin_change_irq && !wake_in.wdt_reset_evt && !wake_in.bod_reset_evt)
			|=> (r_reg.st == SPG_PDOWN);
	endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("power-down left without wake");

	property p_bod_off;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_ACTIVE && sleep_exec && r_reg.arm && brownout_sleep_off_act)
			|=> (r_reg.msel == 2'h2) ? !bod_enable : (bod_enable == bod_fuse_en);
	endproperty
	a_bod_off: assert property (p_bod_off) else $error("brown-out shutdown wrong");

	property p_bod_back;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_PDOWN && r_reg.bod_off && wake_hit)
			|=> (bod_enable == bod_fuse_en) && (r_reg.wake_cnt == 16'(RESET_WAKE_CYC + 4));
	endproperty
	a_bod_back: assert property (p_bod_back) else $error("wake after brown-out off wrong");

	property p_brownout_sleep_off_seq;
		@(posedge sys_clk) disable iff (rst)
		$rose(brownout_sleep_off_bit) |-> !brownout_sleep_off_act ##3 brownout_sleep_off_act [*3] ##1 !brownout_sleep_off_bit;
	endproperty
	a_brownout_sleep_off_seq: assert property (p_brownout_sleep_off_seq) else $error("sleep-off bit timing wrong");

	property p_gate;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_ACTIVE) |-> (periph_clk_en == ~r_reg.pgr) && (pgr_rdata[7:4] == 4'h0);
	endproperty
	a_gate: assert property (p_gate) else $error("gating mismatch in active");

	property p_gate_sleep;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_IDLE) |-> (periph_clk_en == ~r_reg.pgr);
	endproperty
	a_gate_sleep: assert property (p_gate_sleep) else $error("gating mismatch in idle");

	property p_io_block;
		@(posedge sys_clk) disable iff (rst)
		$rose(r_reg.pgr[0]) |-> !periph_io_ack[0];
	endproperty
	a_io_block: assert property (p_io_block) else $error("gated converter answered");

	property p_acomp;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_PDOWN) |-> !acomp_active && (vref_enable == (bod_enable || adc_enable));
	endproperty
	a_acomp: assert property (p_acomp) else $error("comparator active in power-down");

	property p_vref_keep;
		@(posedge sys_clk) disable iff (rst)
		(vref_ready && $past(vref_enable) && vref_enable) |=> vref_enable |-> vref_ready;
	endproperty
	a_vref_keep: assert property (p_vref_keep) else $error("reference lost readiness");

	property p_inbuf;
		@(posedge sys_clk) disable iff (rst)
		(r_reg.st == SPG_PDOWN) |-> (input_buf_en == (wake_pin_mask & ~din_disable));
	endproperty
	a_inbuf: assert property (p_inbuf) else $error("input buffers wrong in power-down");

endmodule

// ===== spg_periph_model.sv
`timescale 1ns/10ps
module spg_periph_model
	import spg_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// clocks handed out by the controller
	input wire spg_clk_t clk_en,
	input wire logic [3:0] periph_clk_en,
	// running state of each gated peripheral
	output logic [3:0][7:0] pcnt
);
	// each peripheral just counts, so a held value shows a stopped clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pcnt <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (periph_clk_en[i] && (clk_en.io || clk_en.adc)) begin
					pcnt[i] <= pcnt[i] + 8'h01;
				end
			end
		end
	end
endmodule

// ===== tb_spg_ctrl.sv
`timescale 1ns/10ps
module tb_spg_ctrl
	import spg_pkg::*;
();
	localparam int WK = 2;
	localparam int RWK = 8;
	localparam int VR = 3;
	logic sys_clk = 1'b0, rst = 1'b1, ccr_wr = 1'b0, pgr_wr = 1'b0, sleep_exec = 1'b0;
	logic [7:0] ccr_wdata = 8'h00, pgr_wdata = 8'h00, ccr_rdata, pgr_rdata, d;
	spg_wake_t wake_in = '0;
	logic bod_fuse_en = 1'b1, wdt_enable = 1'b0, adc_enable = 1'b0, acomp_enable = 1'b0;
	logic adc_conv_start = 1'b0, cpu_run, sleeping, osc_enable, wdt_run, bod_enable;
	logic acomp_active, adc_active, adc_extended, vref_enable, vref_ready, async_keep_en;
	logic [3:0] periph_io_req = 4'h0, periph_io_ack, periph_clk_en;
	logic [5:0] din_disable = 6'h00, wake_pin_mask = 6'h00, input_buf_en;
	spg_clk_t clk_en;
	logic [3:0][7:0] pcnt, snap;
	logic [7:0] goods [8] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h20};
	int fail_count = 0, total_checks = 0, seed = 49706, n;

	always #25 sys_clk = ~sys_clk;

	spg_ctrl #(.WAKE_CYC(WK), .RESET_WAKE_CYC(RWK), .VREF_START_CYC(VR)) spg_ctrl_inst (
		.sys_clk(sys_clk), .rst(rst), .ccr_wr(ccr_wr), .ccr_wdata(ccr_wdata),
		.ccr_rdata(ccr_rdata), .pgr_wr(pgr_wr), .pgr_wdata(pgr_wdata), .pgr_rdata(pgr_rdata),
		.sleep_exec(sleep_exec), .cpu_run(cpu_run), .sleeping(sleeping), .wake_in(wake_in),
		.bod_fuse_en(bod_fuse_en), .wdt_enable(wdt_enable), .adc_enable(adc_enable),
		.acomp_enable(acomp_enable), .adc_conv_start(adc_conv_start),
		.periph_io_req(periph_io_req), .periph_io_ack(periph_io_ack),
		.din_disable(din_disable), .wake_pin_mask(wake_pin_mask), .input_buf_en(input_buf_en),
		.clk_en(clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
		.async_keep_en(async_keep_en), .wdt_run(wdt_run), .bod_enable(bod_enable),
		.acomp_active(acomp_active), .adc_active(adc_active), .adc_extended(adc_extended),
		.vref_enable(vref_enable), .vref_ready(vref_ready));

	spg_periph_model spg_periph_model_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.periph_clk_en(periph_clk_en), .pcnt(pcnt));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	// one write strobe; p selects the gate register
	task automatic wr(input logic p, input logic [7:0] v);
		@(negedge sys_clk);
		ccr_wr = !p;
		pgr_wr = p;
		ccr_wdata = v;
		pgr_wdata = v;
		@(negedge sys_clk);
		ccr_wr = 1'b0;
		pgr_wr = 1'b0;
	endtask

	task automatic do_sleep();
		@(negedge sys_clk);
		sleep_exec = 1'b1;
		@(negedge sys_clk);
		sleep_exec = 1'b0;
	endtask

	function automatic logic [4:0] exp_clk(input logic [1:0] m);
		case (m)
			2'h0: exp_clk = 5'h07;
			2'h1: exp_clk = 5'h02;
			2'h2: exp_clk = 5'h00;
			default: exp_clk = 5'h1F;
		endcase
	endfunction

	function automatic logic [15:0] exp_wake(input logic [1:0] m, input logic off);
		exp_wake = (m == 2'h2) ? 16'((off ? RWK : WK) + 5) : 16'h0005;
	endfunction

	// only wake pins keep their buffers once both clocks stop
	function automatic logic [15:0] exp_buf(input logic [1:0] m, input logic [5:0] msk, dis);
		exp_buf = {10'h000, ((m == 2'h2) ? msk : 6'h3F) & ~dis};
	endfunction

	// off: the timed sleep-off sequence was just written, mode already armed
	task automatic sleep_cycle(input logic [1:0] m, input logic [7:0] bad, good, input logic off);
		logic [15:0] e;
		adc_enable = 1'($random(seed));
		acomp_enable = 1'($random(seed));
		wdt_enable = 1'($random(seed));
		wake_pin_mask = 6'($random(seed));
		din_disable = 6'($random(seed));
		if (!off) wr(1'b0, {2'h0, 1'b1, m, 3'h0});
		else cyc(4);
		do_sleep();
		chk("sleeping", 16'(m != 2'h3), 16'(sleeping));
		chk("clk_en", 16'(exp_clk(m)), 16'(clk_en));
		chk("async", 16'h0001, 16'(async_keep_en));
		if (m == 2'h3) return;
		chk("osc", 16'(m != 2'h2), 16'(osc_enable));
		chk("wdt", 16'(wdt_enable), 16'(wdt_run));
		chk("adc", 16'(adc_enable), 16'(adc_active));
		chk("acomp", 16'(acomp_enable & (m != 2'h2)), 16'(acomp_active));
		chk("bufs", exp_buf(m, wake_pin_mask, din_disable), 16'(input_buf_en));
		e = 16'(bod_fuse_en & !(off & (m == 2'h2)));
		chk("bod", e, 16'(bod_enable));
		wake_in = bad;
		cyc(3);
		chk("no_wake", 16'h0001, 16'(sleeping));
		wake_in = good;
		n = 0;
		while (cpu_run !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		wake_in = '0;
		chk("wake_cyc", exp_wake(m, off), n[15:0]);
		chk("bod_back", 16'(bod_fuse_en), 16'(bod_enable));
		if (adc_enable) chk("vref_kept", 16'h0001, 16'(vref_ready));
	endtask

	initial begin
		#(20000 * 50);
		fail_count++;
		conclude();
	end

	initial begin
		cyc(10);
		rst = 1'b0;
		cyc(1);
		chk("ccr_rst", 16'h0000, 16'(ccr_rdata));
		chk("pgr_rst", 16'h0000, 16'(pgr_rdata));
		chk("run_rst", 16'h0001, 16'(cpu_run));
		for (int i = 0; i < 8; i++) begin
			d[1:0] = (i == 0) ? 2'h0 : ((i == 1 || i == 7) ? 2'h1 : 2'h2);
			sleep_cycle(d[1:0], (d[1:0] == 2'h0) ? 8'h00 : ((d[1:0] == 2'h1) ? 8'h10 : 8'hE0),
				goods[i], 1'b0);
		end
		sleep_cycle(2'h3, 8'h00, 8'h00, 1'b0);
		wr(1'b0, 8'h10);
		do_sleep();
		chk("unarmed", 16'h0000, 16'(sleeping));
		wr(1'b0, 8'hA0);
		chk("brownout_sleep_off_locked", 16'h0020, 16'(ccr_rdata));
		wr(1'b0, 8'h84);
		wr(1'b0, 8'hB0);
		chk("brownout_sleep_off_set", 16'h00B0, 16'(ccr_rdata));
		sleep_cycle(2'h2, 8'hE0, 8'h04, 1'b1);
		wr(1'b0, 8'h84);
		wr(1'b0, 8'hA0);
		sleep_cycle(2'h0, 8'h00, 8'h80, 1'b1);
		adc_enable = 1'b0;
		periph_io_req = 4'hF;
		repeat (6) begin
			d = 8'($random(seed));
			wr(1'b1, d);
			snap = pcnt;
			cyc(3);
			chk("pgr_rd", {12'h000, d[3:0]}, 16'(pgr_rdata));
			chk("pclk", {12'h000, ~d[3:0]}, 16'(periph_clk_en));
			chk("ack", {12'h000, ~d[3:0]}, 16'(periph_io_ack));
			for (int i = 0; i < 4; i++) begin
				chk("frozen", 16'(d[i]), 16'(pcnt[i] === snap[i]));
			end
		end
		// gating must still bite while the core idles
		wr(1'b0, 8'h20);
		do_sleep();
		chk("pclk_idle", {12'h000, ~d[3:0]}, 16'(periph_clk_en));
		wake_in = 8'h80;
		cyc(6);
		wake_in = '0;
		bod_fuse_en = 1'b0;
		acomp_enable = 1'b0;
		cyc(2);
		chk("vref_off", 16'h0000, 16'(vref_enable));
		adc_enable = 1'b1;
		cyc(1);
		chk("vref_wait", 16'h0000, 16'(vref_ready));
		cyc(VR + 1);
		chk("vref_rdy", 16'h0001, 16'(vref_ready));
		chk("adc_ext", 16'h0001, 16'(adc_extended));
		adc_conv_start = 1'b1;
		cyc(1);
		adc_conv_start = 1'b0;
		cyc(1);
		chk("adc_ext_clr", 16'h0000, 16'(adc_extended));
		conclude();
	end
endmodule
